// file: rtl/pin_port_pkg.sv
// Shared constants for the five-pin port.
// Assumes one 100 MHz core clock and byte addresses on the bus.
package pin_port_pkg;

    // Clock rate and derived periods.
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int CLK_PERIOD_NS = 10;

    // Register byte offsets, one aligned 32-bit word each.
    localparam logic [7:0] OFS_DIR = 8'h00;
    localparam logic [7:0] OFS_LEVEL = 8'h04;
    localparam logic [7:0] OFS_INPUT = 8'h08;
    localparam logic [7:0] OFS_CMD = 8'h0C;
    localparam logic [7:0] OFS_TONE = 8'h10;
    localparam logic [7:0] OFS_ADC = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // Pin roles and direction masks (bit n is pin n, one means output).
    localparam logic [2:0] PIN_SERIAL = 3'h0;
    localparam logic [2:0] PIN_INPUT_ONLY = 3'h3;
    localparam logic [2:0] PIN_ANALOG = 3'h1;
    localparam logic [2:0] PIN_LAST = 3'h4;
    localparam logic [4:0] DIR_FIXED_OUT = 5'h01;
    localparam logic [4:0] DIR_CONFIG = 5'h16;
    localparam logic [4:0] DIR_RESET = 5'h01;
    localparam logic [4:0] LEVEL_RESET = 5'h00;

    // Command word fields.
    localparam int CMD_PIN_LSB = 0;
    localparam int CMD_OP_LSB = 4;
    localparam int CMD_DATA_LSB = 8;

    // Pin operations carried by the command word.
    typedef enum logic [2:0] {
        OP_HIGH = 3'h0,
        OP_LOW = 3'h1,
        OP_TOGGLE = 3'h2,
        OP_MAKE_OUT = 3'h3,
        OP_MAKE_IN = 3'h4,
        OP_SERIAL = 3'h5,
        OP_TONE = 3'h6,
        OP_ADC = 3'h7
    } pin_op_t;

    // Status register bit positions and ADC result layout.
    localparam int STAT_TX_BUSY = 0;
    localparam int STAT_ADC_BUSY = 1;
    localparam int STAT_TONE_ON = 2;
    localparam int STAT_ANALOG = 3;
    localparam int STAT_DOWNLOAD = 4;
    localparam int ADC_VALID_BIT = 8;
    localparam int ADC_BITS = 8;

    // Serial timing and converter settling.
    localparam int SERIAL_BAUD = 4800;
    localparam int SERIAL_BIT_CYCLES = CLK_FREQ_HZ / SERIAL_BAUD;
    localparam int ADC_SETTLE_NS = 1000;
    localparam int ADC_SETTLE_CYCLES = (ADC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] TONE_RESET = 16'h0400;

endpackage

// file: rtl/serial_byte_tx.sv
// Byte transmitter: one start bit, eight data bits LSB first, one stop bit.
// Assumes start is a one-cycle pulse given only while busy is low.
`timescale 1ns/1ps
module serial_byte_tx
    import pin_port_pkg::*;
#(
    parameter int BIT_CYCLES = SERIAL_BIT_CYCLES
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [7:0] data,
    output logic busy,
    output logic txd
);

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_DATA = 2'b11,
        TX_STOP = 2'b10
    } tx_state_t;

    typedef struct packed {
        tx_state_t state;
        logic [15:0] cnt;
        logic [2:0] bitn;
        logic [7:0] shreg;
        logic txd;
        logic busy;
    } tx_regs_t;

    tx_regs_t s;
    tx_regs_t next_s;
    logic bit_end;

    assign bit_end = (s.cnt == 16'(BIT_CYCLES - 1));
    assign busy = s.busy;
    assign txd = s.txd;

    // Line idles high; each bit lasts BIT_CYCLES clocks.
    always_comb
    begin
        next_s = s;
        next_s.cnt = bit_end ? 16'h0000 : s.cnt + 16'h0001;
        case (s.state)
            TX_IDLE:
            begin
                next_s.cnt = 16'h0000;
                next_s.txd = 1'b1;
                if (start)
                begin
                    next_s.state = TX_START;
                    next_s.shreg = data;
                    next_s.txd = 1'b0;
                    next_s.busy = 1'b1;
                end
            end
            TX_START:
            begin
                if (bit_end)
                begin
                    next_s.state = TX_DATA;
                    next_s.bitn = 3'h0;
                    next_s.txd = s.shreg[0];
                end
            end
            TX_DATA:
            begin
                if (bit_end)
                begin
                    next_s.shreg = {1'b0, s.shreg[7:1]};
                    next_s.txd = s.shreg[1];
                    next_s.bitn = s.bitn + 3'h1;
                    if (s.bitn == 3'h7)
                    begin
                        next_s.state = TX_STOP;
                        next_s.txd = 1'b1;
                    end
                end
            end
            default:
            begin
                if (bit_end)
                begin
                    next_s.state = TX_IDLE;
                    next_s.busy = 1'b0;
                end
            end
        endcase
    end

    // Registered state.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s <= '{state: TX_IDLE, cnt: 16'h0000, bitn: 3'h0, shreg: 8'h00,
                   txd: 1'b1, busy: 1'b0};
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule

// file: rtl/sar_adc_ctrl.sv
// Successive-approximation control for a low-resolution converter.
// Assumes an external DAC fed by trial and a comparator
// whose above is high while the input exceeds the trial.
`timescale 1ns/1ps
module sar_adc_ctrl
    import pin_port_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic above,
    output logic [ADC_BITS-1:0] trial,
    output logic [ADC_BITS-1:0] result,
    output logic busy,
    output logic done
);

    typedef enum logic [1:0] {
        ADC_IDLE = 2'b00,
        ADC_SETTLE = 2'b01,
        ADC_DECIDE = 2'b11
    } adc_state_t;

    typedef struct packed {
        adc_state_t state;
        logic [7:0] settle;
        logic [ADC_BITS-1:0] probe;
        logic [ADC_BITS-1:0] trial;
        logic [ADC_BITS-1:0] result;
        logic busy;
        logic done;
    } adc_regs_t;

    adc_regs_t s;
    adc_regs_t next_s;

    assign trial = s.trial;
    assign result = s.result;
    assign busy = s.busy;
    assign done = s.done;

    // Each bit waits for the DAC and comparator to settle before deciding.
    always_comb
    begin
        next_s = s;
        next_s.done = 1'b0;
        case (s.state)
            ADC_IDLE:
            begin
                if (start)
                begin
                    next_s.probe = {1'b1, {(ADC_BITS-1){1'b0}}};
                    next_s.trial = {1'b1, {(ADC_BITS-1){1'b0}}};
                    next_s.settle = 8'h00;
                    next_s.busy = 1'b1;
                    next_s.state = ADC_SETTLE;
                end
            end
            ADC_SETTLE:
            begin
                next_s.settle = s.settle + 8'h01;
                if (s.settle == 8'(ADC_SETTLE_CYCLES - 1))
                begin
                    next_s.state = ADC_DECIDE;
                end
            end
            default:
            begin
                next_s.trial = above ? s.trial : (s.trial & ~s.probe);
                next_s.probe = s.probe >> 1;
                next_s.settle = 8'h00;
                if (s.probe[0])
                begin
                    next_s.result = above ? s.trial : (s.trial & ~s.probe);
                    next_s.busy = 1'b0;
                    next_s.done = 1'b1;
                    next_s.state = ADC_IDLE;
                end
                else
                begin
                    next_s.trial = (above ? s.trial : (s.trial & ~s.probe)) | (s.probe >> 1);
                    next_s.state = ADC_SETTLE;
                end
            end
        endcase
    end

    // Registered state.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule

// file: rtl/pin_port.sv
// Five-pin port: direction control, pin commands, serial, tone, analogue in.
// Assumes an Avalon-MM master on the register side, and loads, a DAC
// and a comparator on the pin side.
// Pin inputs are sampled twice here before use.
//
// Functional notes
// RULE1 - Pin 0 is always an output and pin 3 always an input.
// RULE2 - Pins 1, 2 and 4 are each selectable as input or output.
// RULE3 - Pin 1 offers a low-resolution analogue conversion path.
// RULE4 - After reset all pins are inputs except pin 0, an output.
// RULE5 - High, low, toggle, serial or tone on any pin but pin 3 leaves it an output; a serial command dropped while a byte goes out leaves it as it was.
// RULE6 - Drive-low makes the pin an output, except input-only pin 3, and forces its level low.
// RULE7 - Make-output changes direction only; make-input turns the pin input. Both also stop a tone on the pin, and make-output on pin 1 ends analogue mode.
// RULE8 - Make-input and make-output leave pins 0 and 3 untouched.
// RULE9 - Writing the direction mask sets all directions; one means output.
// RULE10 - Mask bits 0, 3, 5, 6 and 7 are ignored on write.
// RULE11 - An analogue sample request first turns the pin into an input.
// RULE12 - Pin 0 carries download serial data while a download runs.
// RULE13 - Input reads return the pin level synchronised to the core clock.
`timescale 1ns/1ps
module pin_port
    import pin_port_pkg::*;
#(
    parameter int BIT_CYCLES = SERIAL_BIT_CYCLES
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [4:0] pin_in,
    output logic [4:0] pin_out,
    output logic [4:0] pin_oe,
    input wire logic download_active,
    input wire logic download_txd,
    input wire logic adc_above,
    output logic [ADC_BITS-1:0] adc_dac_level
);

    ////////////////////////////////////////////////////////////////////////
    // State and helpers

    typedef struct packed {
        logic [4:0] dir;
        logic [4:0] level;
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic analog;
        logic [15:0] tone_period;
        logic [15:0] tone_cnt;
        logic tone_on;
        logic [2:0] tone_pin;
        logic tone_lvl;
        logic [2:0] tx_pin;
        logic tx_start;
        logic [7:0] tx_data;
        logic adc_start;
        logic [ADC_BITS-1:0] adc_value;
        logic adc_valid;
        logic waitreq;
        logic [31:0] rdata;
        logic [4:0] pin_out;
        logic [4:0] pin_oe;
    } port_regs_t;

    port_regs_t s;
    port_regs_t next_s;

    logic tx_busy;
    logic tx_txd;
    logic adc_busy;
    logic adc_done;
    logic [ADC_BITS-1:0] adc_result;
    logic [ADC_BITS-1:0] adc_trial;
    logic wr_go;
    pin_op_t cmd_op;
    logic [2:0] cmd_pin;
    logic [7:0] cmd_data;

    // Forces the fixed pins whatever is offered.
    function automatic logic [4:0] fix_dirs(input logic [4:0] d);
        fix_dirs = (d & DIR_CONFIG) | DIR_FIXED_OUT; // RULE1
    endfunction

    // One-hot pin select; numbers past the last pin select none.
    function automatic logic [4:0] pin_bit(input logic [2:0] p);
        pin_bit = (p <= PIN_LAST) ? 5'(5'h01 << p) : 5'h00;
    endfunction

    // Applies write byte enables to a stored word.
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        merge = (new_v & m) | (old_v & ~m);
    endfunction

    // A write takes effect only on the cycle the master sees waitrequest low.
    assign wr_go = write && !s.waitreq;
    assign cmd_op = pin_op_t'(writedata[CMD_OP_LSB +: 3]);
    assign cmd_pin = writedata[CMD_PIN_LSB +: 3];
    assign cmd_data = writedata[CMD_DATA_LSB +: 8];

    assign readdata = s.rdata;
    assign waitrequest = s.waitreq;
    assign pin_out = s.pin_out;
    assign pin_oe = s.pin_oe;
    assign adc_dac_level = adc_trial;

    ////////////////////////////////////////////////////////////////////////
    // Serial transmitter and analogue converter

    serial_byte_tx #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_tx (
        .core_clk(core_clk),
        .rst(rst),
        .start(s.tx_start),
        .data(s.tx_data),
        .busy(tx_busy),
        .txd(tx_txd)
    );

    sar_adc_ctrl u_adc (
        .core_clk(core_clk),
        .rst(rst),
        .start(s.adc_start),
        .above(adc_above),
        .trial(adc_trial),
        .result(adc_result),
        .busy(adc_busy),
        .done(adc_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    // Bus handshake, register writes, pin commands and the pin drivers.
    always_comb
    begin
        logic [4:0] sel;
        logic [4:0] drive;
        logic [31:0] word;
        sel = pin_bit(cmd_pin);
        drive = 5'h00;
        word = 32'h0000_0000;
        next_s = s;
        next_s.tx_start = 1'b0;
        next_s.adc_start = 1'b0;

        // Two-stage sampling of the pins; only the second stage is used.
        next_s.sync1 = pin_in;
        next_s.sync2 = s.sync1; // RULE13

        // Waitrequest drops for one cycle after a request is seen, so each
        // access completes two cycles after it is raised.
        next_s.waitreq = !((read || write) && s.waitreq);

        // Read data is captured while waitrequest is still high.
        if (read && s.waitreq)
        begin
            if (address == OFS_DIR)
            begin
                word = {27'h0, s.dir};
            end
            else if (address == OFS_LEVEL)
            begin
                word = {27'h0, s.level};
            end
            else if (address == OFS_INPUT)
            begin
                word = {27'h0, s.sync2}; // RULE13
            end
            else if (address == OFS_TONE)
            begin
                word = {16'h0, s.tone_period};
            end
            else if (address == OFS_ADC)
            begin
                word[ADC_BITS-1:0] = s.adc_value; // RULE3
                word[ADC_VALID_BIT] = s.adc_valid;
            end
            else if (address == OFS_STATUS)
            begin
                word[STAT_TX_BUSY] = tx_busy || s.tx_start;
                word[STAT_ADC_BUSY] = adc_busy || s.adc_start;
                word[STAT_TONE_ON] = s.tone_on;
                word[STAT_ANALOG] = s.analog;
                word[STAT_DOWNLOAD] = download_active;
            end
            next_s.rdata = word;
        end

        // A finished conversion is kept until the next sample request.
        if (adc_done)
        begin
            next_s.adc_value = adc_result;
            next_s.adc_valid = 1'b1;
        end

        // Whole-mask and level writes; reserved mask bits are dropped.
        if (wr_go && address == OFS_DIR)
        begin
            word = merge({27'h0, s.dir}, writedata, byteenable);
            next_s.dir = fix_dirs(word[4:0]); // RULE9 RULE10
            if (word[PIN_ANALOG])
            begin
                next_s.analog = 1'b0;
            end
        end
        else if (wr_go && address == OFS_LEVEL)
        begin
            word = merge({27'h0, s.level}, writedata, byteenable);
            next_s.level = word[4:0];
        end
        else if (wr_go && address == OFS_TONE)
        begin
            word = merge({16'h0, s.tone_period}, writedata, byteenable);
            next_s.tone_period = word[15:0];
        end
        else if (wr_go && address == OFS_CMD && byteenable[0] && sel != 5'h00)
        begin
            // A driving command on the tone pin stops the tone.
            if (s.tone_on && cmd_pin == s.tone_pin && cmd_op != OP_ADC)
            begin
                next_s.tone_on = 1'b0;
            end
            case (cmd_op)
                OP_HIGH:
                begin
                    next_s.dir = fix_dirs(s.dir | sel); // RULE5
                    next_s.level = s.level | sel;
                end
                OP_LOW:
                begin
                    next_s.dir = fix_dirs(s.dir | sel); // RULE5 RULE6
                    next_s.level = s.level & ~sel; // RULE6
                end
                OP_TOGGLE:
                begin
                    next_s.dir = fix_dirs(s.dir | sel); // RULE5
                    next_s.level = s.level ^ sel;
                end
                OP_MAKE_OUT:
                begin
                    // Level is left as it was, so the pin may come up high.
                    next_s.dir = fix_dirs(s.dir | sel); // RULE7 RULE8
                end
                OP_MAKE_IN:
                begin
                    next_s.dir = fix_dirs(s.dir & ~sel); // RULE7 RULE8
                end
                OP_SERIAL:
                begin
                    // A byte offered while one is still going out is dropped.
                    if (!tx_busy && !s.tx_start)
                    begin
                        next_s.dir = fix_dirs(s.dir | sel); // RULE5
                        next_s.tx_pin = cmd_pin;
                        next_s.tx_data = cmd_data;
                        next_s.tx_start = 1'b1;
                    end
                end
                OP_TONE:
                begin
                    next_s.dir = fix_dirs(s.dir | sel); // RULE5
                    next_s.tone_on = (s.tone_period != 16'h0000);
                    next_s.tone_pin = cmd_pin;
                    next_s.tone_cnt = 16'h0000;
                    next_s.tone_lvl = 1'b0;
                end
                default:
                begin
                    // Only the analogue pin converts; a busy converter refuses.
                    if (cmd_pin == PIN_ANALOG && !adc_busy && !s.adc_start)
                    begin
                        next_s.dir = s.dir & ~sel; // RULE11
                        next_s.analog = 1'b1; // RULE11
                        next_s.adc_valid = adc_done; // A landing result wins.
                        next_s.adc_start = 1'b1; // RULE3
                    end
                end
            endcase
            // Driving the analogue pin as an output ends analogue use.
            if (cmd_pin == PIN_ANALOG && cmd_op != OP_ADC && cmd_op != OP_MAKE_IN)
            begin
                next_s.analog = 1'b0;
            end
        end

        // Square wave with a half period of tone_period clocks.
        if (s.tone_on)
        begin
            if (s.tone_cnt >= s.tone_period - 16'h0001)
            begin
                next_s.tone_cnt = 16'h0000;
                next_s.tone_lvl = !s.tone_lvl;
            end
            else
            begin
                next_s.tone_cnt = s.tone_cnt + 16'h0001;
            end
        end

        // Pin drivers: level latch, then tone and serial overlays, and
        // last the download line on pin 0, which wins.
        drive = s.level;
        if (s.tone_on)
        begin
            drive = (drive & ~pin_bit(s.tone_pin)) | (s.tone_lvl ? pin_bit(s.tone_pin) : 5'h00);
        end
        if (tx_busy)
        begin
            drive = (drive & ~pin_bit(s.tx_pin)) | (tx_txd ? pin_bit(s.tx_pin) : 5'h00);
        end
        if (download_active)
        begin
            drive[PIN_SERIAL] = download_txd; // RULE12
        end
        next_s.pin_out = drive;
        next_s.pin_oe = fix_dirs(s.dir); // RULE1 RULE2
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    // Power-up leaves every pin an input except pin 0.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s <= '0;
            s.dir <= DIR_RESET; // RULE4
            s.level <= LEVEL_RESET;
            s.tone_period <= TONE_RESET;
            s.waitreq <= 1'b1;
            s.pin_oe <= DIR_RESET; // RULE4
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule

// file: dv/pin_loads.sv
// Switches and loads on the five pins, and an analogue source.
// Assumes the port's pin outputs and enables are wired in.
`timescale 1ns/1ps
module pin_loads
(
    input wire logic [4:0] pin_out,
    input wire logic [4:0] pin_oe,
    input wire logic [4:0] switch_level,
    input wire logic [7:0] analog_level,
    input wire logic [7:0] dac_level,
    output logic [4:0] pin_level,
    output logic above
);
    // A driven pin reads back its own level, an undriven one its switch.
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & switch_level);
    // The comparator trips only while the source is strictly above the trial.
    assign above = analog_level > dac_level;
endmodule

// file: dv/pin_port_assertions.sv
// Concurrent checks on the port's handshake and pin directions.
// Assumes binding into the port's top module; sees only its ports.
`timescale 1ns/1ps
module pin_port_assertions
    import pin_port_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    input wire logic waitrequest,
    input wire logic [4:0] pin_out,
    input wire logic [4:0] pin_oe,
    input wire logic download_active,
    input wire logic download_txd
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    logic cmd_go, cfg_pin;
    // A command write request seen at this edge (taken one cycle later), and a selectable pin in it.
    assign cmd_go = write && waitrequest && byteenable[0] && address == OFS_CMD;
    assign cfg_pin = writedata[2:0] inside {3'h1, 3'h2, 3'h4};
    ////////////////////////////////////////
    // Effects of a taken write show on the pins two cycles after it completes.
    a_fixed_dirs: assert property (pin_oe[0] && !pin_oe[3])
        else $error("fixed pin direction broken");
    a_reset_state: assert property ($fell(rst) |-> pin_oe == DIR_RESET && !pin_out)
        else $error("pins wrong after reset");
    a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("waitrequest not low for one cycle");
    a_mask_write: assert property (write && waitrequest && byteenable[0] && address == OFS_DIR
        |=> ##2 pin_oe == {$past(writedata[4], 3), 1'b0, $past(writedata[2:1], 3), 1'b1})
        else $error("mask write not applied");
    a_low_cmd: assert property (cmd_go && cfg_pin && writedata[6:4] == OP_LOW
        |=> ##2 pin_oe[$past(writedata[2:0], 3)] && !pin_out[$past(writedata[2:0], 3)])
        else $error("drive low not applied");
    a_make_out: assert property (cmd_go && cfg_pin && writedata[6:4] == OP_MAKE_OUT
        |=> ##2 pin_oe[$past(writedata[2:0], 3)] && pin_out == $past(pin_out, 3))
        else $error("make output changed level");
    a_adc_input: assert property (cmd_go && writedata[6:4] == OP_ADC && writedata[2:0] == 3'h1
        |=> ##2 !pin_oe[1])
        else $error("sample pin not made input");
    a_download: assert property ($past(download_active) && !$past(rst)
        |-> pin_out[0] == $past(download_txd)) else $error("pin 0 not following download");
endmodule
bind pin_port pin_port_assertions chk (.*);

// file: dv/five_pin_direction_config_port_test.sv
// Bench for the pin port: directions, levels, sampling, download.
// Assumes the loads model and bound checker are compiled with it.
`timescale 1ns/1ps
module five_pin_direction_config_port_test import pin_port_pkg::*;;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic read = 1'b0, write = 1'b0;
    logic download_active = 1'b0;
    logic download_txd = 1'b1;
    logic [7:0] address = 8'h00;
    logic [7:0] analog_level = 8'h5B;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] writedata = 32'h0;
    logic [4:0] switch_level = 5'h1F;
    logic [31:0] readdata, rd;
    logic [4:0] pin_in, pin_out, pin_oe;
    logic waitrequest, adc_above;
    logic [ADC_BITS-1:0] adc_dac_level;
    int fail_count = 0, checks_done = 0;
    pin_port #(.BIT_CYCLES(8)) DUT (.*);
    pin_loads loads (.pin_out(pin_out), .pin_oe(pin_oe), .switch_level(switch_level),
        .analog_level(analog_level), .dac_level(adc_dac_level), .pin_level(pin_in),
        .above(adc_above));
    ////////////////////////////////////////
    // Free-running core clock.
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic check(input logic [31:0] got, exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: %s", $time, what);
            fail_count++;
        end
    endtask
    // One access; the request stands until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        @(posedge core_clk);
        while (waitrequest !== 1'b0)
        begin
            @(posedge core_clk);
        end
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge core_clk);
    endtask
    // Command, then two cycles so its effect has reached the pins.
    task automatic cmd(input logic [2:0] op, input logic [2:0] p);
        bus(1'b1, OFS_CMD, {25'h0, op, 1'b0, p});
        repeat (2) @(posedge core_clk);
    endtask
    ////////////////////////////////////////
    task automatic test_mask();
        check(pin_oe, DIR_RESET, "reset dirs");
        bus(1'b0, OFS_DIR, 32'h0);
        check(rd, 32'h1, "reset mask");
        bus(1'b1, OFS_DIR, 32'hFF);
        @(posedge core_clk);
        check(pin_oe, 5'h17, "all out");
        bus(1'b1, OFS_DIR, 32'h0E);
        bus(1'b0, OFS_DIR, 32'h0);
        check(rd[4:0], 5'h07, "bit 3 ignored");
        bus(1'b1, OFS_DIR, 32'hE8);
        bus(1'b1, 8'h40, 32'hFF);
        bus(1'b0, 8'h40, 32'h0);
        check(rd, 32'h0, "unmapped read");
        check(pin_oe, 5'h01, "high bits ignored");
        $display("test_mask done");
    endtask
    task automatic test_pins();
        logic [2:0] cfg[3] = '{3'h1, 3'h2, 3'h4};
        foreach (cfg[i])
        begin
            cmd(OP_LOW, cfg[i]);
            check({pin_oe[cfg[i]], pin_out[cfg[i]]}, 2'b10, "low");
            cmd(OP_HIGH, cfg[i]);
            cmd(OP_MAKE_IN, cfg[i]);
            check(pin_oe[cfg[i]], 1'b0, "make in");
            bus(1'b0, OFS_INPUT, 32'h0);
            check({rd[cfg[i]], rd[3]}, 2'b11, "input read");
            cmd(OP_MAKE_OUT, cfg[i]);
            check({pin_oe[cfg[i]], pin_out[cfg[i]]}, 2'b11, "make out");
            cmd(OP_TOGGLE, cfg[i]);
            check(pin_out[cfg[i]], 1'b0, "toggle");
        end
        cmd(OP_MAKE_IN, 3'h0);
        cmd(OP_MAKE_OUT, 3'h3);
        check({pin_oe[3], pin_oe[0]}, 2'b01, "fixed pins");
        cmd(OP_MAKE_IN, 3'h4);
        cmd(OP_SERIAL, 3'h4);
        cmd(OP_MAKE_IN, 3'h2);
        cmd(OP_TONE, 3'h2);
        check({pin_oe[4], pin_oe[2]}, 2'b11, "serial, tone");
        cmd(OP_LOW, 3'h2);
        repeat (100) @(posedge core_clk);
        $display("test_pins done");
    endtask
    task automatic test_adc();
        cmd(OP_HIGH, 3'h1);
        cmd(OP_ADC, 3'h1);
        check(pin_oe[1], 1'b0, "sample dir");
        for (int n = 0; n < 600 && rd[ADC_VALID_BIT] !== 1'b1; n++)
            bus(1'b0, OFS_ADC, 32'h0);
        // A strict comparator may lose one count, so bit 0 is not judged.
        check(rd[8:1], {1'b1, analog_level[7:1]}, "sample value");
        bus(1'b0, OFS_STATUS, 32'h0);
        check(rd[STAT_ANALOG], 1'b1, "analogue mode");
        $display("test_adc done");
    endtask
    task automatic test_download();
        download_active <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            download_txd <= i[0];
            repeat (4) @(posedge core_clk);
            check(pin_out[0], i[0], "download bit");
        end
        download_active <= 1'b0;
        cmd(OP_HIGH, 3'h0);
        check(pin_out[0], 1'b1, "pin 0 after download");
        $display("test_download done");
    endtask
    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Reset for ten cycles, then run every scenario in turn.
    initial
    begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        test_mask();
        test_pins();
        test_adc();
        test_download();
        test_done();
    end
    // Watchdog well past the thousand or so cycles the scenarios need.
    initial
    begin
        #200_000;
        fail_count++;
        test_done();
    end
endmodule
